// [timer_params.svh]
// Offsets, field positions, reset values and timing counts of the timer block.
// Assumes inclusion by bare name from the block's design files.
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_CTRL      8'h00
`define OFS_CNT_LOW   8'h04
`define OFS_CNT_HIGH  8'h08
`define OFS_CNT_INIT  8'h0C
`define OFS_MODULO    8'h10
`define OFS_TRIG_SEL  8'h14
`define OFS_SYNC      8'h18
`define OFS_FLAGS     8'h1C
`define OFS_IRQ_EN    8'h20
`define OFS_PAIR0     8'h24
`define OFS_CHVAL0    8'h40

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define CTRL_FEATURE  0
`define CTRL_INIT_EN  1
`define CTRL_CAPTURE_TEST_ENABLE  2
`define CTRL_CLOCK_SOURCE_SELECT_LO  3
`define CTRL_CLOCK_SOURCE_SELECT_HI  4
`define CTRL_W        5
`define CTRL_RESET    5'h00
`define PCFG_W        9
`define PCFG_RESET    9'h000
`define MODULO_RESET  16'hFFFF
`define NUM_CH        6
`define NUM_PAIR      3

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 50
`define FILT_TIME_NS  200
`define FILT_CYCLES   ((`FILT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [timer_types_pkg.sv]
// Types shared by the timer trigger and dual edge capture files.
// Assumes nothing of its surroundings.
package timer_types_pkg;

  // Per pair configuration, laid out as the pair register bits 8..0.
  typedef struct packed {
    logic       filter_en;
    logic [1:0] odd_edge;
    logic [1:0] even_edge;
    logic       continuous;
    logic       combine;
    logic       arm;
    logic       dual_en;
  } pair_cfg_t;

  typedef struct packed {
    logic even_hit;
    logic odd_hit;
  } pair_evt_t;

  typedef enum logic [1:0] {
    SEQ_EVEN = 2'b01,
    SEQ_ODD  = 2'b10
  } seq_state_t;

endpackage : timer_types_pkg

// [input_glitch_filter.sv]
// Glitch filter for one capture input.
// Assumes the input is synchronous to clock.
`timescale 1ns/1ps
`include "timer_params.svh"
module input_glitch_filter (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Control and data
  input  wire logic enable,
  input  wire logic sig_in,
  output logic      sig_out
);
  localparam logic [3:0] FILT_LEN = 4'(`FILT_CYCLES);

  logic       stable_r;
  logic [3:0] cnt_r;

  // A new level must hold for the whole filter time before it passes.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r    <= 4'h0;
      stable_r <= 1'b0;
    end else if (sig_in == stable_r) begin
      cnt_r <= 4'h0;
    end else if (cnt_r == FILT_LEN - 4'h1) begin
      cnt_r    <= 4'h0;
      stable_r <= sig_in;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  assign sig_out = enable ? stable_r : sig_in;
endmodule : input_glitch_filter

// [pair_edge_sequencer.sv]
// Edge detection and capture sequencing for one channel pair.
// Assumes a filtered even-channel input synchronous to clock.
`timescale 1ns/1ps
module pair_edge_sequencer
  import timer_types_pkg::*;
(
  // Clock and reset
  input  wire logic      clock,
  input  wire logic      rst_n,
  // Configuration and status
  input  wire logic      feature_en,
  input  pair_cfg_t      cfg,
  input  wire logic      even_flag,
  // Input and events
  input  wire logic      sig_in,
  output pair_evt_t      evt
);
  seq_state_t state_r;
  logic       prev_r;
  logic       active;
  logic       ehit;
  logic       ohit;

  function automatic logic edge_hit(input logic [1:0] sel, input logic prv, input logic cur);
    edge_hit = (sel[0] & ~prv & cur) | (sel[1] & prv & ~cur);
  endfunction : edge_hit

  // Only the even input is looked at; the odd input is not a port at all.
  assign active = feature_en & cfg.dual_en & cfg.arm;
  assign ehit   = edge_hit(cfg.even_edge, prev_r, sig_in);
  assign ohit   = edge_hit(cfg.odd_edge, prev_r, sig_in);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) prev_r <= 1'b0;
    else        prev_r <= sig_in;
  end

  // Once the first edge is taken, the odd edge selection decides the second, and only while the even flag is set.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SEQ_EVEN;
    end else if (!active) begin
      state_r <= SEQ_EVEN;
    end else begin
      case (state_r)
        SEQ_EVEN: if (ehit) state_r <= SEQ_ODD;
        SEQ_ODD:  if (ohit && even_flag) state_r <= SEQ_EVEN;
        default:  state_r <= SEQ_EVEN;
      endcase
    end
  end

  assign evt.even_hit = active & (state_r == SEQ_EVEN) & ehit;
  assign evt.odd_hit  = active & (state_r == SEQ_ODD) & ohit & even_flag;

  a_odd_after_even: assert property (@(posedge clock) disable iff (!rst_n)
    evt.odd_hit |-> even_flag && $past(state_r == SEQ_EVEN) == 1'b0)
    else $error("odd capture without prior even capture");
endmodule : pair_edge_sequencer

// [timer_trigger_dual_edge_capture.sv]
// Trigger, capture test and dual edge capture logic of a 16-bit timer.
// Assumes one AHB-Lite master and capture inputs synchronous to clock.
// Behaviour
// - Selected channel match fires trigger when enabled
// - Match triggers only in combine mode
// - Init trigger on automatic reload to initial
// - Init trigger on counter byte writes
// - Init trigger on counter synchronization load
// - Init trigger when clock source starts from initial
// - Init trigger only in combine mode
// - Capture test freezes counter, writes load directly
// - Both bytes written: load values, flags, advance
// - Values read written count; counter reads next
// - Byte read coherency stays active in test
// - Dual capture uses even input only
// - Even input filter only on channels 0, 2
// - Continuous select and edges choose mode, measurement
// - Even edge sets even flag, interrupt
// - Odd edge sets odd flag only after even
// - Counter captured into even, odd values
// - One-shot captures one pair, then disarms
// - Continuous capture repeats while armed
//
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "timer_params.svh"
module timer_trigger_dual_edge_capture
  import timer_types_pkg::*;
(
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  // Capture inputs, one per pair (even channel)
  input  wire logic [`NUM_PAIR-1:0] capture_in,
  // Triggers and channel interrupt requests
  output logic [`NUM_CH-1:0]        match_trigger,
  output logic                      init_trigger,
  output logic [`NUM_CH-1:0]        channel_irq
);
  // --------------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------------
  logic                 addr_ok;
  logic                 rd_acc;
  logic                 wr_pend_r;
  logic [7:0]           wa_r;
  logic [31:0]          hrdata_r;
  logic [31:0]          rd_mux;
  logic [7:0]           ra;
  logic                 wr_ctrl, wr_lo, wr_hi, wr_sync, wr_flags, wr_any_cnt;

  assign addr_ok   = hsel & htrans[1] & hready;
  assign rd_acc    = addr_ok & ~hwrite;
  assign ra        = haddr[7:0];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // Zero wait states: writes land at the end of the data phase.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      wa_r      <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok & hwrite;
      if (addr_ok) wa_r <= ra;
    end
  end

  assign wr_ctrl    = wr_pend_r && wa_r == `OFS_CTRL;
  assign wr_lo      = wr_pend_r && wa_r == `OFS_CNT_LOW;
  assign wr_hi      = wr_pend_r && wa_r == `OFS_CNT_HIGH;
  assign wr_sync    = wr_pend_r && wa_r == `OFS_SYNC && hwdata[0];
  assign wr_flags   = wr_pend_r && wa_r == `OFS_FLAGS;
  assign wr_any_cnt = wr_lo | wr_hi;

  function automatic logic wr_hit(input logic pend, input logic [7:0] a, input logic [7:0] ofs);
    wr_hit = pend && a == ofs;
  endfunction : wr_hit

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  logic [`CTRL_W-1:0]   ctrl_r;
  logic [15:0]          init_r, mod_r;
  logic [`NUM_CH-1:0]   trig_sel_r, irq_en_r;
  logic                 feature_en, init_en, capture_test_enable;
  logic [1:0]           clock_source_select;

  assign feature_en = ctrl_r[`CTRL_FEATURE];
  assign init_en    = ctrl_r[`CTRL_INIT_EN];
  assign capture_test_enable    = ctrl_r[`CTRL_CAPTURE_TEST_ENABLE];
  assign clock_source_select       = ctrl_r[`CTRL_CLOCK_SOURCE_SELECT_HI:`CTRL_CLOCK_SOURCE_SELECT_LO];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r     <= `CTRL_RESET;
      init_r     <= 16'h0000;
      mod_r      <= `MODULO_RESET;
      trig_sel_r <= 6'h00;
      irq_en_r   <= 6'h00;
    end else begin
      if (wr_ctrl) ctrl_r <= hwdata[`CTRL_W-1:0];
      if (wr_hit(wr_pend_r, wa_r, `OFS_CNT_INIT)) init_r <= hwdata[15:0];
      if (wr_hit(wr_pend_r, wa_r, `OFS_MODULO)) mod_r <= hwdata[15:0];
      if (wr_hit(wr_pend_r, wa_r, `OFS_TRIG_SEL)) trig_sel_r <= hwdata[5:0];
      if (wr_hit(wr_pend_r, wa_r, `OFS_IRQ_EN)) irq_en_r <= hwdata[5:0];
    end
  end

  // --------------------------------------------------------------------------
  // Counter and capture test
  // --------------------------------------------------------------------------
  logic [15:0]          cnt_r;
  logic [15:0]          cnt_step;
  logic                 running, reload;
  logic                 lo_done_r, hi_done_r, ct_pend_r;

  // Only up-counting is built; capture test relies on software setting it so.
  assign running  = clock_source_select != 2'b00 && !capture_test_enable;
  assign reload   = running && cnt_r == mod_r;
  assign cnt_step = (cnt_r == mod_r) ? init_r : cnt_r + 16'h0001;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 16'h0000;
    end else if (capture_test_enable && wr_lo) begin
      cnt_r <= {cnt_r[15:8], hwdata[7:0]};
    end else if (capture_test_enable && wr_hi) begin
      cnt_r <= {hwdata[7:0], cnt_r[7:0]};
    end else if (ct_pend_r) begin
      cnt_r <= cnt_step;
    end else if (wr_any_cnt || wr_sync) begin
      cnt_r <= init_r;
    end else if (running) begin
      cnt_r <= cnt_step;
    end
  end

  // Both bytes in either order arm a one-cycle load of all channel values.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lo_done_r <= 1'b0;
      hi_done_r <= 1'b0;
      ct_pend_r <= 1'b0;
    end else begin
      ct_pend_r <= capture_test_enable && ((wr_lo && hi_done_r) || (wr_hi && lo_done_r));
      if (!capture_test_enable || ct_pend_r) begin
        lo_done_r <= 1'b0;
        hi_done_r <= 1'b0;
      end else begin
        if (wr_lo) lo_done_r <= 1'b1;
        if (wr_hi) hi_done_r <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pair configuration and dual edge capture
  // --------------------------------------------------------------------------
  pair_cfg_t            pcfg_r [`NUM_PAIR];
  pair_evt_t            evt    [`NUM_PAIR];
  logic [15:0]          cv_r   [`NUM_CH];
  logic [15:0]          odd_buf_r [`NUM_PAIR];
  logic [`NUM_CH-1:0]   flag_r;
  logic [`NUM_PAIR-1:0] filt_sig;

  genvar p;
  generate
    for (p = 0; p < `NUM_PAIR; p++) begin : g_pair
      localparam logic [7:0] POFS = 8'(`OFS_PAIR0 + 4 * p);

      // A software write of 1 to the arm bit wins over the hardware disarm.
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          pcfg_r[p] <= `PCFG_RESET;
        end else if (wr_hit(wr_pend_r, wa_r, POFS)) begin
          pcfg_r[p] <= hwdata[`PCFG_W-1:0];
        end else if (evt[p].odd_hit && !pcfg_r[p].continuous) begin
          pcfg_r[p].arm <= 1'b0;
        end
      end

      // The filter sits on every pair but can be enabled on the first two pairs only.
      input_glitch_filter u_filt (
        .clock   (clock),
        .rst_n   (rst_n),
        .enable  (pcfg_r[p].filter_en && p < 2),
        .sig_in  (capture_in[p]),
        .sig_out (filt_sig[p])
      );

      pair_edge_sequencer u_seq (
        .clock      (clock),
        .rst_n      (rst_n),
        .feature_en (feature_en),
        .cfg        (pcfg_r[p]),
        .even_flag  (flag_r[2*p]),
        .sig_in     (filt_sig[p]),
        .evt        (evt[p])
      );

      // Continuous mode keeps the arm bit, so pairs repeat while it stays set.
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          cv_r[2*p]   <= 16'h0000;
          cv_r[2*p+1] <= 16'h0000;
        end else if (ct_pend_r) begin
          cv_r[2*p]   <= cnt_r;
          cv_r[2*p+1] <= cnt_r;
        end else begin
          if (evt[p].even_hit) cv_r[2*p] <= cnt_r;
          else if (wr_hit(wr_pend_r, wa_r, 8'(`OFS_CHVAL0 + 8 * p))) cv_r[2*p] <= hwdata[15:0];
          if (evt[p].odd_hit) cv_r[2*p+1] <= cnt_r;
          else if (wr_hit(wr_pend_r, wa_r, 8'(`OFS_CHVAL0 + 8 * p + 4)))
            cv_r[2*p+1] <= hwdata[15:0];
        end
      end

      // Reading the even value freezes the odd value for the following read.
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) odd_buf_r[p] <= 16'h0000;
        else if (rd_acc && ra == 8'(`OFS_CHVAL0 + 8 * p)) odd_buf_r[p] <= cv_r[2*p+1];
      end
    end
  endgenerate

  // Hardware setting a flag wins over a write-one-to-clear in the same cycle.
  genvar c;
  generate
    for (c = 0; c < `NUM_CH; c++) begin : g_flag
      logic hw_set;
      assign hw_set = ct_pend_r || (c % 2 == 0 ? evt[c/2].even_hit : evt[c/2].odd_hit);
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) flag_r[c] <= 1'b0;
        else if (hw_set) flag_r[c] <= 1'b1;
        else if (wr_flags && hwdata[c]) flag_r[c] <= 1'b0;
      end
    end
  endgenerate

  assign channel_irq = flag_r & irq_en_r;

  // --------------------------------------------------------------------------
  // Triggers
  // --------------------------------------------------------------------------
  logic [`NUM_CH-1:0]   match_nxt, match_r;
  logic                 init_nxt, init_r_trig, clock_source_select_start;

  // Match is judged on the value the counter is stepping to, so it pulses once.
  always_comb begin
    for (int j = 0; j < `NUM_CH; j++) begin
      match_nxt[j] = feature_en && trig_sel_r[j] && pcfg_r[j/2].combine
                     && running && cnt_step == cv_r[j];
    end
  end

  assign clock_source_select_start = wr_ctrl && clock_source_select == 2'b00 && cnt_r == init_r
                      && hwdata[`CTRL_CLOCK_SOURCE_SELECT_HI:`CTRL_CLOCK_SOURCE_SELECT_LO] != 2'b00;
  assign init_nxt   = init_en && pcfg_r[0].combine
                      && (reload || wr_any_cnt || wr_sync || clock_source_select_start);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      match_r     <= 6'h00;
      init_r_trig <= 1'b0;
    end else begin
      match_r     <= match_nxt;
      init_r_trig <= init_nxt;
    end
  end

  assign match_trigger = match_r;
  assign init_trigger  = init_r_trig;

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  logic [7:0]           cnt_hi_buf_r;

  // The low byte read latches the high byte, so a byte pair is coherent.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) cnt_hi_buf_r <= 8'h00;
    else if (rd_acc && ra == `OFS_CNT_LOW) cnt_hi_buf_r <= cnt_r[15:8];
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (ra)
      `OFS_CTRL:     rd_mux = {27'h0, ctrl_r};
      `OFS_CNT_LOW:  rd_mux = {24'h0, cnt_r[7:0]};
      `OFS_CNT_HIGH: rd_mux = {24'h0, cnt_hi_buf_r};
      `OFS_CNT_INIT: rd_mux = {16'h0, init_r};
      `OFS_MODULO:   rd_mux = {16'h0, mod_r};
      `OFS_TRIG_SEL: rd_mux = {26'h0, trig_sel_r};
      `OFS_FLAGS:    rd_mux = {26'h0, flag_r};
      `OFS_IRQ_EN:   rd_mux = {26'h0, irq_en_r};
      default: begin
        for (int k = 0; k < `NUM_PAIR; k++) begin
          if (ra == 8'(`OFS_PAIR0 + 4 * k)) rd_mux = {23'h0, pcfg_r[k]};
          if (ra == 8'(`OFS_CHVAL0 + 8 * k)) rd_mux = {16'h0, cv_r[2*k]};
          if (ra == 8'(`OFS_CHVAL0 + 8 * k + 4)) rd_mux = {16'h0, odd_buf_r[k]};
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) hrdata_r <= 32'h0000_0000;
    else if (rd_acc) hrdata_r <= rd_mux;
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_match_cause: assert property (@(posedge clock) disable iff (!rst_n)
    match_trigger[0] |-> $past(feature_en && trig_sel_r[0] && cnt_step == cv_r[0]))
    else $error("match trigger without a selected match");
  a_match_combine: assert property (@(posedge clock) disable iff (!rst_n)
    $past(!pcfg_r[0].combine) |-> match_trigger[1:0] == 2'b00)
    else $error("match trigger outside combine mode");
  a_reload_trig: assert property (@(posedge clock) disable iff (!rst_n)
    reload && init_en && pcfg_r[0].combine |=> init_trigger)
    else $error("reload gave no init trigger");
  a_write_trig: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_lo || wr_hi) && init_en && pcfg_r[0].combine |=> init_trigger)
    else $error("counter write gave no init trigger");
  a_init_combine: assert property (@(posedge clock) disable iff (!rst_n)
    init_trigger |-> $past(init_en && pcfg_r[0].combine))
    else $error("init trigger outside combine mode");
  a_test_freeze: assert property (@(posedge clock) disable iff (!rst_n)
    capture_test_enable && !wr_pend_r && !ct_pend_r |=> $stable(cnt_r))
    else $error("counter moved in capture test");
  a_test_load: assert property (@(posedge clock) disable iff (!rst_n)
    ct_pend_r |=> flag_r == 6'h3F && cv_r[5] == $past(cnt_r) && cnt_r == $past(cnt_step))
    else $error("capture test load wrong");
  a_oneshot_disarm: assert property (@(posedge clock) disable iff (!rst_n)
    evt[1].odd_hit && !pcfg_r[1].continuous && !wr_pend_r |=> !pcfg_r[1].arm)
    else $error("one-shot did not disarm");
  a_cont_keeps: assert property (@(posedge clock) disable iff (!rst_n)
    evt[1].odd_hit && pcfg_r[1].continuous && !wr_pend_r |=> pcfg_r[1].arm)
    else $error("continuous capture disarmed");
  a_even_capture: assert property (@(posedge clock) disable iff (!rst_n)
    evt[1].even_hit && !ct_pend_r |=> cv_r[2] == $past(cnt_r) && flag_r[2])
    else $error("even capture wrong");

  c_pair_done: cover property (@(posedge clock) disable iff (!rst_n)
    evt[1].even_hit ##[1:200] evt[1].odd_hit);
  c_test_load: cover property (@(posedge clock) disable iff (!rst_n) ct_pend_r);
  c_match: cover property (@(posedge clock) disable iff (!rst_n) match_trigger[0]);
endmodule : timer_trigger_dual_edge_capture

// [signal_partner.sv]
// Far side of the timer: the signal source on the capture inputs and the on-chip
// consumers of the triggers. Assumes the bench calls send_pulse between its scenarios.
`timescale 1ns/1ps
module signal_partner (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Trigger consumers
  input  wire logic [5:0] match_trigger,
  input  wire logic       init_trigger,
  // Signal source
  output logic [2:0]      capture_in
);
  int         match_cnt;
  int         init_cnt;
  logic       wide_seen;
  logic [6:0] last_r;
  initial capture_in = 3'h0;
  // A trigger that stays high for a second cycle is remembered.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      match_cnt <= 0;
      init_cnt  <= 0;
      wide_seen <= 1'b0;
      last_r    <= 7'h00;
    end else begin
      match_cnt <= match_cnt + $countones(match_trigger);
      init_cnt  <= init_cnt + int'(init_trigger);
      wide_seen <= wide_seen | (|(last_r & {match_trigger, init_trigger}));
      last_r    <= {match_trigger, init_trigger};
    end
  end
  // One rising edge, then one falling edge after len cycles.
  task automatic send_pulse(input int k, input int len);
    @(posedge clock);
    capture_in[k] <= 1'b1;
    repeat (len) @(posedge clock);
    capture_in[k] <= 1'b0;
  endtask : send_pulse
endmodule : signal_partner

// [timer_trigger_dual_edge_capture_tb.sv]
// Self-checking bench of the timer trigger and dual edge capture block.
// Assumes the partner model and the design files are compiled before it.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module timer_trigger_dual_edge_capture_tb;
  logic clock = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, capture_in;
  logic [5:0] match_trigger, channel_irq;
  wire hready;
  logic init_trigger;
  int miscompares = 0, checks_done = 0, cycles = 0, m0, i0;
  always #25 clock = ~clock;
  timer_trigger_dual_edge_capture timer_trigger_dual_edge_capture_i (.clock(clock),
    .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .capture_in(capture_in), .match_trigger(match_trigger),
    .init_trigger(init_trigger), .channel_irq(channel_irq));
  signal_partner signal_partner_i (.clock(clock), .rst_n(rst_n),
    .match_trigger(match_trigger), .init_trigger(init_trigger), .capture_in(capture_in));
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= wr; hsize <= 3'h2;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    rv = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d); bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a); bus(1'b0, a, 32'h0); endtask : rd
  task automatic marks(); m0 = signal_partner_i.match_cnt; i0 = signal_partner_i.init_cnt;
  endtask : marks
  task automatic t_init();
    wr(8'h24, 32'h4); wr(8'h00, 32'h3);
    marks(); wr(8'h04, 32'h0); repeat (3) @(posedge clock);
    `CHK("init on byte write", 1, signal_partner_i.init_cnt - i0)
    marks(); wr(8'h18, 32'h1); repeat (3) @(posedge clock);
    `CHK("init on sync", 1, signal_partner_i.init_cnt - i0)
    marks(); wr(8'h00, 32'hB); repeat (3) @(posedge clock);
    `CHK("init on clock start", 1, signal_partner_i.init_cnt - i0)
    wr(8'h00, 32'h3); wr(8'h24, 32'h0);
    marks(); wr(8'h08, 32'h0); repeat (3) @(posedge clock);
    `CHK("init without combine", 0, signal_partner_i.init_cnt - i0)
  endtask : t_init
  task automatic t_capture_test_enable();
    wr(8'h00, 32'h5); wr(8'h04, 32'h34); wr(8'h08, 32'h12); repeat (3) @(posedge clock);
    rd(8'h1C); `CHK("all flags", 32'h3F, rv)
    rd(8'h40); `CHK("value 0", 32'h1234, rv)
    rd(8'h50); `CHK("value 4", 32'h1234, rv)
    rd(8'h54); `CHK("value 5", 32'h1234, rv)
    repeat (5) @(posedge clock);
    rd(8'h04); `CHK("count low", 32'h35, rv)
    rd(8'h08); `CHK("count high", 32'h12, rv)
    wr(8'h1C, 32'h3F);
  endtask : t_capture_test_enable
  task automatic t_match();
    wr(8'h04, 32'h10); wr(8'h08, 32'h0); wr(8'h1C, 32'h3F); wr(8'h10, 32'h20);
    wr(8'h14, 32'h1); wr(8'h24, 32'h4); wr(8'h00, 32'hB); repeat (10) @(posedge clock);
    marks(); repeat (99) @(posedge clock);
    `CHK("match count", 3, signal_partner_i.match_cnt - m0)
    `CHK("reload init count", 3, signal_partner_i.init_cnt - i0)
    `CHK("pulse width", 1'b0, signal_partner_i.wide_seen)
    wr(8'h24, 32'h0); @(posedge clock); marks(); repeat (66) @(posedge clock);
    `CHK("match without combine", 0, signal_partner_i.match_cnt - m0)
    `CHK("reload without combine", 0, signal_partner_i.init_cnt - i0)
    wr(8'h14, 32'h0); wr(8'h10, 32'hFFFF);
  endtask : t_match
  task automatic t_dual(input logic [31:0] cfg, input int gap, input int span,
                        input logic [31:0] after);
    logic [15:0] ev;
    wr(8'h00, 32'h9); wr(8'h1C, 32'h3F); wr(8'h20, 32'hC); wr(8'h28, cfg);
    signal_partner_i.send_pulse(1, gap - 1);
    signal_partner_i.send_pulse(1, 4); repeat (3) @(posedge clock);
    `CHK("pair irqs", 6'h0C, channel_irq)
    rd(8'h48); ev = rv[15:0]; rd(8'h4C);
    `CHK("captured span", 16'(span), 16'(rv[15:0] - ev))
    rd(8'h28); `CHK("arm state", after, rv)
    wr(8'h1C, 32'h3F); @(posedge clock);
    `CHK("irqs cleared", 6'h00, channel_irq)
  endtask : t_dual
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    t_init();
    t_capture_test_enable();
    t_match();
    t_dual(32'h93, 6, 5, 32'h91);
    t_dual(32'h5B, 6, 6, 32'h5B);
    test_done();
  end
endmodule : timer_trigger_dual_edge_capture_tb
